// ---- cuc_regs.svh ----
/*
  Constants of the command unit control block: command byte fields and
  codes, acknowledge bit positions and reset values.
  Assumes it is included by the package only, by its bare name.
*/
`ifndef CUC_REGS_SVH
`define CUC_REGS_SVH

// ==========================================================
// Command byte
`define CUC_CMD_LSB 0
`define CUC_CMD_MSB 3
`define CUC_CMD_NOP 4'h0
`define CUC_CMD_START 4'h1
`define CUC_CMD_RESUME 4'h2
`define CUC_CMD_RST 8'h00

// ==========================================================
// Acknowledge byte and status
`define CUC_ACK_DONE_BIT 7
`define CUC_ACK_LEFT_BIT 5
`define CUC_STATUS_RST 2'h0

// ==========================================================
// Pointers
`define CUC_PTR_RST 32'h00000000

`endif

// ---- cuc_pkg.sv ----
/*
  Types shared by the command unit control block and its status module.
  Assumes cuc_regs.svh is on the include path.
*/
package cuc_pkg;
  `include "cuc_regs.svh"

  // ==========================================================
  // Types
  typedef enum logic [1:0] {cuc_idle, cuc_suspended, cuc_active} cuc_state_t;
  typedef enum logic [1:0] {cuc_fetch, cuc_wait_block, cuc_wait_reread} cuc_phase_t;
  typedef enum logic [1:0] {cuc_kind_none, cuc_kind_start, cuc_kind_resume, cuc_kind_bad} cuc_kind_t;

  typedef struct packed {
    logic end_of_list_flag;
    logic suspend_flag;
    logic [31:0] link;
  } cuc_block_info_t;

  typedef struct packed {
    logic rx_end_of_frame;
    logic buffer_prefetch;
    logic tx_dma_done;
    logic action_done;
    logic counter_dump;
  } cuc_prio_t;

  typedef struct packed {
    logic left_active;
    logic block_done;
  } cuc_events_t;

  // ==========================================================
  // Command decode
  function automatic cuc_kind_t cuc_decode(input logic [7:0] cmd_byte);
    logic [3:0] field;
    field = cmd_byte[`CUC_CMD_MSB:`CUC_CMD_LSB];
    if (field == `CUC_CMD_NOP) begin
      return cuc_kind_none;
    end else if (field == `CUC_CMD_START) begin
      return cuc_kind_start;
    end else if (field == `CUC_CMD_RESUME) begin
      return cuc_kind_resume;
    end
    return cuc_kind_bad;
  endfunction : cuc_decode
endpackage : cuc_pkg

// ---- cuc_irq_status.sv ----
/*
  Sticky interrupt status with host acknowledge and an active-low line.
  Assumes events are one-cycle pulses on the same clock.
*/
module cuc_irq_status import cuc_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire cuc_events_t event_in,
  input wire logic ack_wr_in,
  input wire logic [7:0] ack_byte_in,
  output cuc_events_t status_out,
  output logic irq_line_n_out
);
  cuc_events_t ack_mask;
  cuc_events_t next_status;

  // ==========================================================
  // Status update: a new event wins over a same-cycle acknowledge
  always_comb begin
    ack_mask.left_active = ack_wr_in & ack_byte_in[`CUC_ACK_LEFT_BIT];
    ack_mask.block_done = ack_wr_in & ack_byte_in[`CUC_ACK_DONE_BIT];
    next_status = (status_out & ~ack_mask) | event_in; // RULE_02
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_out <= `CUC_STATUS_RST; // RULE_20
    end else begin
      status_out <= next_status;
    end
  end

  // Line follows the next status so it is released (goes high) in the acknowledge cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_line_n_out <= 1'b1;
    end else begin
      irq_line_n_out <= ~|next_status; // RULE_03
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking

  ack_clear_a: assert property (disable iff (!rst_n_in) // RULE_02
    ack_wr_in && ack_byte_in[`CUC_ACK_DONE_BIT] && !event_in.block_done |=> !status_out.block_done)
    else $error("acknowledged done bit not cleared");
  irq_release_a: assert property (disable iff (!rst_n_in) // RULE_03
    ##1 irq_line_n_out == (status_out == `CUC_STATUS_RST))
    else $error("interrupt line disagrees with status");
  event_sticky_a: assert property (disable iff (!rst_n_in) // RULE_02
    event_in.left_active |=> status_out.left_active && !irq_line_n_out)
    else $error("event not latched or line not asserted");
endmodule : cuc_irq_status

// ---- cuc_command_unit.sv ----
/*
  Command unit control state machine: accepts list start and resume
  commands, walks the action_list block by block and raises events.
  Assumes a fetch engine answers block and re-read requests, and that the
  host writes the command byte only while it reads zero.
*/
// Contract
// RULE_01 - Host acknowledges serviced events by writing ones
// RULE_02 - Acknowledge write clears matching status bits immediately
// RULE_03 - Interrupt line released only when status empty
// RULE_04 - Three states, idle after reset
// RULE_05 - End-of-list completion: idle, both events
// RULE_06 - Suspend flag only: suspended, left-active event
// RULE_07 - No flags: stay active, fetch next block
// RULE_08 - Accept: read command, clear byte, act
// RULE_09 - Acceptance waits for higher-priority work
// RULE_10 - Keep pending start and resume flags
// RULE_11 - Host issues start only when idle/suspended
// RULE_12 - Start loads pointer from general pointer
// RULE_13 - Start from idle/suspended goes active
// RULE_14 - Resume uses stored link, no link re-read
// RULE_15 - Resume re-reads suspend flag, may resuspend
// RULE_16 - Resume while active re-checks suspend flag
// RULE_17 - Resume while idle is ignored
// RULE_18 - Suspended keeps next link address
// RULE_19 - Host waits for cleared byte between commands
// RULE_20 - Reset clears state, flags and status
module cuc_command_unit import cuc_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic [31:0] gen_ptr_in,
  input wire cuc_prio_t prio_busy_in,
  input wire logic ack_wr_in,
  input wire logic [7:0] ack_byte_in,
  input wire logic block_done_in,
  input wire cuc_block_info_t block_info_in,
  input wire logic reread_done_in,
  input wire logic reread_suspend_in,
  output logic [7:0] cmd_byte_out,
  output logic block_req_out,
  output logic [31:0] block_addr_out,
  output logic reread_req_out,
  output logic [31:0] reread_addr_out,
  output cuc_state_t unit_state_out,
  output logic pending_start_flag_out,
  output logic pending_resume_flag_out,
  output logic left_active_event_out,
  output logic block_done_event_out,
  output cuc_events_t int_status_out,
  output logic irq_line_n_out
);
  cuc_phase_t phase;
  cuc_kind_t kind;
  logic [31:0] next_ptr;
  logic [31:0] cur_addr;
  logic accept;
  logic acc_start;
  logic acc_resume_susp;
  logic acc_resume_act;
  logic blk_end;
  logic reread_end;
  logic recheck;
  logic fetch_now;
  cuc_events_t events;

  // ==========================================================
  // Acceptance decode
  always_comb begin
    kind = cuc_decode(cmd_byte_out); // RULE_08
    accept = (cmd_byte_out != `CUC_CMD_RST) && (prio_busy_in == '0); // RULE_09
    // Start while active has no defined action and is dropped
    acc_start = accept && (kind == cuc_kind_start) && (unit_state_out != cuc_active); // RULE_13
    acc_resume_susp = accept && (kind == cuc_kind_resume) && (unit_state_out == cuc_suspended); // RULE_17
    acc_resume_act = accept && (kind == cuc_kind_resume) && (unit_state_out == cuc_active)
      && (phase != cuc_wait_reread);
    blk_end = (unit_state_out == cuc_active) && (phase == cuc_wait_block) && block_done_in;
    reread_end = (unit_state_out == cuc_active) && (phase == cuc_wait_reread) && reread_done_in;
    recheck = blk_end && !block_info_in.end_of_list_flag && block_info_in.suspend_flag
      && (pending_resume_flag_out || acc_resume_act); // RULE_16
    fetch_now = (unit_state_out == cuc_active) && (phase == cuc_fetch);
  end

  // ==========================================================
  // Command byte: cleared on acceptance, host writes only when clear
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cmd_byte_out <= `CUC_CMD_RST;
    end else if (accept) begin
      cmd_byte_out <= `CUC_CMD_RST; // RULE_08
    end else if (cmd_wr_in && (cmd_byte_out == `CUC_CMD_RST)) begin
      cmd_byte_out <= cmd_byte_in; // RULE_19
    end
  end

  // ==========================================================
  // Unit state and phase
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      unit_state_out <= cuc_idle; // RULE_04
      phase <= cuc_fetch;
    end else begin
      unique case (unit_state_out)
        cuc_idle: begin
          if (acc_start) begin
            unit_state_out <= cuc_active; // RULE_13
            phase <= cuc_fetch;
          end
        end
        cuc_suspended: begin
          if (acc_start) begin
            unit_state_out <= cuc_active; // RULE_13
            phase <= cuc_fetch;
          end else if (acc_resume_susp) begin
            unit_state_out <= cuc_active; // RULE_15
            phase <= cuc_wait_reread;
          end
        end
        cuc_active: begin
          unique case (phase)
            cuc_fetch: begin
              phase <= cuc_wait_block;
            end
            cuc_wait_block: begin
              if (block_done_in) begin
                if (block_info_in.end_of_list_flag) begin
                  unit_state_out <= cuc_idle; // RULE_05
                  phase <= cuc_fetch;
                end else if (recheck) begin
                  phase <= cuc_wait_reread; // RULE_16
                end else if (block_info_in.suspend_flag) begin
                  unit_state_out <= cuc_suspended; // RULE_06
                  phase <= cuc_fetch;
                end else begin
                  phase <= cuc_fetch; // RULE_07
                end
              end
            end
            default: begin
              if (reread_done_in) begin
                if (reread_suspend_in) begin
                  unit_state_out <= cuc_suspended; // RULE_15
                end
                phase <= cuc_fetch;
              end
            end
          endcase
        end
        default: begin
          unit_state_out <= cuc_idle;
          phase <= cuc_fetch;
        end
      endcase
    end
  end

  // ==========================================================
  // Pointers: the link is kept across a suspension
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      next_ptr <= `CUC_PTR_RST;
      cur_addr <= `CUC_PTR_RST;
    end else begin
      if (acc_start) begin
        next_ptr <= gen_ptr_in; // RULE_12
      end else if (blk_end) begin
        next_ptr <= block_info_in.link; // RULE_18
      end
      if (fetch_now) begin
        cur_addr <= next_ptr;
      end
    end
  end

  // ==========================================================
  // Pending request flags
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pending_start_flag_out <= 1'b0; // RULE_20
      pending_resume_flag_out <= 1'b0;
    end else begin
      if (acc_start) begin
        pending_start_flag_out <= 1'b1; // RULE_10
      end else if (fetch_now) begin
        pending_start_flag_out <= 1'b0;
      end
      if (blk_end) begin
        pending_resume_flag_out <= 1'b0; // RULE_10
      end else if (acc_resume_act) begin
        pending_resume_flag_out <= 1'b1; // RULE_16
      end
    end
  end

  // ==========================================================
  // Requests to the fetch engine
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      block_req_out <= 1'b0;
      block_addr_out <= `CUC_PTR_RST;
      reread_req_out <= 1'b0;
      reread_addr_out <= `CUC_PTR_RST;
    end else begin
      block_req_out <= fetch_now; // RULE_07
      if (fetch_now) begin
        block_addr_out <= next_ptr; // RULE_12
      end
      // Only the suspend flag is re-read; the link stays in next_ptr
      reread_req_out <= acc_resume_susp || recheck; // RULE_14
      if (acc_resume_susp || recheck) begin
        reread_addr_out <= cur_addr;
      end
    end
  end

  // ==========================================================
  // Events
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      left_active_event_out <= 1'b0;
      block_done_event_out <= 1'b0;
    end else begin
      left_active_event_out <= (blk_end && (block_info_in.end_of_list_flag
        || block_info_in.suspend_flag) && !recheck) || (reread_end && reread_suspend_in); // RULE_06
      block_done_event_out <= blk_end && block_info_in.end_of_list_flag; // RULE_05
    end
  end

  always_comb begin
    events.left_active = left_active_event_out;
    events.block_done = block_done_event_out;
  end

  cuc_irq_status u_irq (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .event_in(events),
    .ack_wr_in(ack_wr_in),
    .ack_byte_in(ack_byte_in),
    .status_out(int_status_out),
    .irq_line_n_out(irq_line_n_out)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking

  cmd_clear_a: assert property (disable iff (!rst_n_in) // RULE_08
    accept |=> cmd_byte_out == `CUC_CMD_RST)
    else $error("command byte not cleared on acceptance");
  prio_wait_a: assert property (disable iff (!rst_n_in) // RULE_09
    (prio_busy_in != '0) && (cmd_byte_out != `CUC_CMD_RST) |=> cmd_byte_out == $past(cmd_byte_out))
    else $error("command accepted during higher-priority work");
  start_load_a: assert property (disable iff (!rst_n_in) // RULE_12
    acc_start |=> unit_state_out == cuc_active ##1 block_req_out && block_addr_out == $past(gen_ptr_in, 2))
    else $error("start did not fetch from general pointer");
  end_list_a: assert property (disable iff (!rst_n_in) // RULE_05
    blk_end && block_info_in.end_of_list_flag
    |=> unit_state_out == cuc_idle && left_active_event_out && block_done_event_out)
    else $error("end of list handling wrong");
  suspend_a: assert property (disable iff (!rst_n_in) // RULE_06
    blk_end && !block_info_in.end_of_list_flag && block_info_in.suspend_flag && !recheck
    |=> unit_state_out == cuc_suspended && left_active_event_out && !block_done_event_out)
    else $error("suspend handling wrong");
  continue_a: assert property (disable iff (!rst_n_in) // RULE_07
    blk_end && !block_info_in.end_of_list_flag && !block_info_in.suspend_flag
    |=> unit_state_out == cuc_active ##1 block_req_out && block_addr_out == $past(block_info_in.link, 2))
    else $error("next block not fetched from link");
  resume_idle_a: assert property (disable iff (!rst_n_in) // RULE_17
    accept && kind == cuc_kind_resume && unit_state_out == cuc_idle |=> unit_state_out == cuc_idle)
    else $error("resume left idle");
  resume_susp_a: assert property (disable iff (!rst_n_in) // RULE_14
    acc_resume_susp |=> reread_req_out && !block_req_out && block_addr_out == $past(block_addr_out))
    else $error("resume did not re-read suspend flag only");
  reset_state_a: assert property (@(posedge clock_in) // RULE_20
    !rst_n_in |=> unit_state_out == cuc_idle && !pending_start_flag_out && !pending_resume_flag_out)
    else $error("reset did not clear state and flags");

  start_cov_c: cover property (disable iff (!rst_n_in) acc_start ##[1:40] block_done_event_out);
  suspend_cov_c: cover property (disable iff (!rst_n_in) acc_resume_susp ##[1:40] block_req_out);
  recheck_cov_c: cover property (disable iff (!rst_n_in) recheck ##[1:40] reread_end);
endmodule : cuc_command_unit

// ---- cuc_fetch_model.sv ----
/*
  Fetch engine model: answers block and re-read requests delay_in plus one cycles after taking them.
  Assumes block flags follow the address: suspend when addr[0] and addr[7:4] is 0,
  end of list when addr[7:4] equals addr[11:8]; the link is addr plus 10h.
*/
module cuc_fetch_model import cuc_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic block_req_in,
  input wire logic [31:0] block_addr_in,
  input wire logic reread_req_in,
  input wire logic [3:0] delay_in,
  input wire logic reread_s_in,
  output logic block_done_out,
  output cuc_block_info_t block_info_out,
  output logic reread_done_out,
  output logic reread_suspend_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic busy;
  logic rr;
  logic [31:0] addr;
  // ==========================================================
  // Answer
  always @(posedge clock_in) begin
    block_done_out <= 1'b0;
    reread_done_out <= 1'b0;
    // Released lines toggle so stale info never passes for valid
    block_info_out <= ~block_info_out;
    reread_suspend_out <= ~reread_suspend_out;
    if (!rst_n_in) begin
      busy <= 1'b0;
      block_info_out <= '0;
      reread_suspend_out <= 1'b0;
    end else if (block_req_in || reread_req_in) begin
      busy <= 1'b1;
      rr <= reread_req_in;
      cnt <= delay_in;
      addr <= block_addr_in;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      if (rr) begin
        reread_done_out <= 1'b1;
        reread_suspend_out <= reread_s_in;
      end else begin
        block_done_out <= 1'b1;
        block_info_out <= {addr[7:4] == addr[11:8], addr[0] && addr[7:4] == 4'h0, addr + 32'h10};
      end
    end
  end
endmodule : cuc_fetch_model

// ---- tb.sv ----
/*
  Self-checking bench of the command unit with a fetch engine model.
  Assumes the host side is driven here at the falling edge, one command at a time.
*/
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin $display("BAD %s exp %h seen %h", nm, e, g); n_fail++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cuc_pkg::*;
  logic clock_in, rst_n_in, cmd_wr_in, ack_wr_in, block_done_in, reread_done_in, reread_suspend_in;
  logic [7:0] cmd_byte_in, ack_byte_in, cmd_byte_out;
  logic [31:0] gen_ptr_in, block_addr_out, reread_addr_out;
  cuc_prio_t prio_busy_in;
  cuc_block_info_t block_info_in;
  logic block_req_out, reread_req_out, pending_start_flag_out, pending_resume_flag_out;
  logic left_active_event_out, block_done_event_out, irq_line_n_out, reread_s;
  cuc_state_t unit_state_out;
  cuc_events_t int_status_out;
  logic [3:0] delay;
  logic [34:0] exp_q[$];
  logic [34:0] seen, want;
  int n_fail, tests_run, seed, n_reread;
  cuc_command_unit u_cuc_command_unit (.clock_in, .rst_n_in, .cmd_wr_in, .cmd_byte_in, .gen_ptr_in,
    .prio_busy_in, .ack_wr_in, .ack_byte_in, .block_done_in, .block_info_in, .reread_done_in,
    .reread_suspend_in, .cmd_byte_out, .block_req_out, .block_addr_out, .reread_req_out, .reread_addr_out,
    .unit_state_out, .pending_start_flag_out, .pending_resume_flag_out, .left_active_event_out,
    .block_done_event_out, .int_status_out, .irq_line_n_out);
  cuc_fetch_model u_cuc_fetch_model (.clock_in, .rst_n_in, .block_req_in(block_req_out),
    .block_addr_in(block_addr_out), .reread_req_in(reread_req_out), .delay_in(delay), .reread_s_in(reread_s),
    .block_done_out(block_done_in), .block_info_out(block_info_in), .reread_done_out(reread_done_in),
    .reread_suspend_out(reread_suspend_in));
  // ==========================================================
  // Clock, watchdog and report
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    finish_test();
  end
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // Result monitor: every block request or event pulse takes the oldest note
  always @(negedge clock_in) begin
    seen = {block_req_out, left_active_event_out, block_done_event_out, block_addr_out};
    // Re-read pulses are counted and checked against the scenarios after the slow blocks
    if (rst_n_in === 1'b1 && reread_req_out === 1'b1) begin
      n_reread++;
    end
    if (rst_n_in === 1'b1 && seen[34:32] !== 3'b000) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h0;
      `CHK("result", want, seen)
    end
  end
  // ==========================================================
  // Host tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick
  task automatic note(input logic [2:0] k, input logic [31:0] a);
    exp_q.push_back({k, a});
  endtask : note
  task automatic wr_cmd(input logic [7:0] b, input logic [31:0] p);
    cmd_byte_in = b;
    gen_ptr_in = p;
    cmd_wr_in = 1'b1;
    tick(1);
    cmd_wr_in = 1'b0;
  endtask : wr_cmd
  // Waits for a cleared command byte and, unless only_byte, the state and an empty queue
  task automatic wait_until(input cuc_state_t s, input bit only_byte);
    int i;
    i = 0;
    while ((cmd_byte_out !== 8'h00 || (!only_byte && (unit_state_out !== s || exp_q.size() != 0))) && i < 400) begin
      tick(1);
      i++;
    end
    // One more cycle lets status follow the last event pulse
    tick(1);
    if (i == 400) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_until
  task automatic ack(input logic [7:0] b);
    ack_byte_in = b;
    ack_wr_in = 1'b1;
    tick(1);
    ack_wr_in = 1'b0;
    tick(1);
  endtask : ack
  // ==========================================================
  // Scenarios
  initial begin
    seed = 43;
    {rst_n_in, cmd_wr_in, ack_wr_in, reread_s} = 4'h0;
    cmd_byte_in = 8'h00;
    ack_byte_in = 8'h00;
    gen_ptr_in = 32'h0;
    prio_busy_in = '0;
    delay = 4'h0;
    tick(8);
    rst_n_in = 1'b1;
    `CHK("state", cuc_idle, unit_state_out)
    `CHK("status", 2'b00, int_status_out)
    `CHK("irq", 1'b1, irq_line_n_out)
    `CHK("flags", 2'b00, {pending_start_flag_out, pending_resume_flag_out})
    // Each higher-priority source alone holds a resume that idle then ignores
    for (int i = 0; i < 5; i++) begin
      prio_busy_in = cuc_prio_t'(5'h01 << i);
      wr_cmd(8'h02, 32'h0);
      tick(4);
      `CHK("held byte", 8'h02, cmd_byte_out)
      prio_busy_in = '0;
      wait_until(cuc_idle, 1'b0);
      `CHK("resume idle", cuc_idle, unit_state_out)
    end
    // Four block chain ending on end of list, random fetch delay
    delay = 4'($random(seed)) & 4'h7;
    for (int a = 0; a < 4; a++) note(3'b100, 32'h300 + 32'h10 * a);
    note(3'b011, 32'h330);
    prio_busy_in = cuc_prio_t'(5'($random(seed)) | 5'h01);
    wr_cmd(8'h01, 32'h300);
    tick(3);
    `CHK("byte", 8'h01, cmd_byte_out)
    prio_busy_in = '0;
    tick(1);
    `CHK("byte clear", 8'h00, cmd_byte_out)
    `CHK("active", cuc_active, unit_state_out)
    `CHK("pend start", 1'b1, pending_start_flag_out)
    wait_until(cuc_idle, 1'b0);
    `CHK("status", 2'b11, int_status_out)
    `CHK("irq low", 1'b0, irq_line_n_out)
    ack(8'h80);
    `CHK("status", 2'b10, int_status_out)
    `CHK("irq held", 1'b0, irq_line_n_out)
    ack(8'h20);
    `CHK("irq", 1'b1, irq_line_n_out)
    // End of list with suspend also set
    note(3'b100, 32'h001);
    note(3'b011, 32'h001);
    wr_cmd(8'h01, 32'h001);
    wait_until(cuc_idle, 1'b0);
    ack(8'ha0);
    `CHK("ack both", 3'b001, {int_status_out, irq_line_n_out})
    // Suspend, resume into a still set flag, then resume into a cleared one
    note(3'b100, 32'h101);
    note(3'b010, 32'h101);
    wr_cmd(8'h01, 32'h101);
    wait_until(cuc_suspended, 1'b0);
    reread_s = 1'b1;
    note(3'b010, 32'h101);
    wr_cmd(8'h02, 32'h0);
    wait_until(cuc_suspended, 1'b0);
    `CHK("reread addr", 32'h101, reread_addr_out)
    reread_s = 1'b0;
    note(3'b100, 32'h111);
    note(3'b011, 32'h111);
    wr_cmd(8'h02, 32'h0);
    wait_until(cuc_idle, 1'b0);
    // Start from suspended takes the general pointer
    note(3'b100, 32'h101);
    note(3'b010, 32'h101);
    wr_cmd(8'h01, 32'h101);
    wait_until(cuc_suspended, 1'b0);
    note(3'b100, 32'h000);
    note(3'b011, 32'h000);
    wr_cmd(8'h01, 32'h000);
    wait_until(cuc_idle, 1'b0);
    // Slow blocks: an unknown code while active is dropped, resume while active skips the suspend
    delay = 4'hc;
    note(3'b100, 32'h101);
    note(3'b100, 32'h111);
    note(3'b011, 32'h111);
    wr_cmd(8'h01, 32'h101);
    wait_until(cuc_active, 1'b1);
    wr_cmd(8'h07, 32'h001);
    wait_until(cuc_active, 1'b1);
    wr_cmd(8'h02, 32'h0);
    wait_until(cuc_active, 1'b1);
    `CHK("pend resume", 1'b1, pending_resume_flag_out)
    wait_until(cuc_idle, 1'b0);
    ack(8'ha0);
    `CHK("irq", 1'b1, irq_line_n_out)
    `CHK("rereads", 3, n_reread)
    // Reset while suspended with an event pending returns everything to idle
    note(3'b100, 32'h101);
    note(3'b010, 32'h101);
    wr_cmd(8'h01, 32'h101);
    wait_until(cuc_suspended, 1'b0);
    `CHK("irq low", 1'b0, irq_line_n_out)
    rst_n_in = 1'b0;
    tick(2);
    rst_n_in = 1'b1;
    `CHK("reset", 7'b0000100, {unit_state_out, int_status_out, irq_line_n_out, pending_start_flag_out, pending_resume_flag_out})
    finish_test();
  end
endmodule : tb
